// ===== include/eisvm_pkg.sv
// Constants and types for the external interrupt sense and vector map block
package eisvm_pkg;

    // Register byte addresses on the APB bus
    localparam logic [7:0]  ADDR_CTRL          = 8'h00;
    localparam logic [7:0]  ADDR_STATUS        = 8'h04;
    localparam logic [7:0]  ADDR_CC            = 8'h08;

    // External interrupt control register layout
    localparam logic [7:0]  CTRL_RESET         = 8'h00;
    localparam int          CTRL_SENSE_HI_LSB  = 6;
    localparam int          CTRL_POL_B         = 5;
    localparam int          CTRL_SENSE_LO_LSB  = 3;
    localparam int          CTRL_POL_A         = 2;
    localparam int          CTRL_TOP_EDGE      = 1;
    localparam int          CTRL_TOP_EN        = 0;
    localparam int          CTRL_SENSE_LSB     = 2;

    // Status register layout
    localparam int          STAT_REQ_LSB       = 0;
    localparam int          STAT_SRC_LSB       = 16;
    localparam int          STAT_PENDING       = 20;
    localparam int          STAT_WAKE          = 21;

    // Condition code register
    localparam logic [7:0]  CC_RESET           = 8'hEA;
    localparam logic [7:0]  CC_FIXED_ONES      = 8'hC0;
    localparam int          CC_I1              = 5;
    localparam int          CC_I0              = 3;
    localparam logic [1:0]  PRIO_LEVEL0        = 2'b10;
    localparam logic [1:0]  PRIO_LEVEL3        = 2'b11;

    // Sensitivity codes
    localparam logic [1:0]  SENSE_FALL_LOW     = 2'b00;
    localparam logic [1:0]  SENSE_RISE         = 2'b01;
    localparam logic [1:0]  SENSE_FALL         = 2'b10;
    localparam logic [1:0]  SENSE_BOTH         = 2'b11;

    // Sources, numbered by falling hardware priority
    localparam int          NUM_SRC            = 14;
    localparam int          NUM_LINES          = 4;
    localparam logic [3:0]  SRC_TOP            = 4'h0;
    localparam logic [3:0]  SRC_LINE0          = 4'h2;
    localparam logic [13:0] HALT_CAP_MASK      = 14'h20BF;
    localparam logic [13:0] HALT_COND_MASK     = 14'h2080;

    // Vector addresses
    localparam logic [15:0] VEC_RESET          = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP           = 16'hFFFC;
    localparam logic [15:0] VEC_SRC0           = 16'hFFFA;

    // Pin group widths
    localparam int          PINS_A             = 4;
    localparam int          PINS_F             = 3;
    localparam int          PINS_B             = 8;

    typedef enum logic [2:0] {
        CMD_NONE    = 3'b000,
        CMD_ENABLE  = 3'b001,
        CMD_DISABLE = 3'b010,
        CMD_HALT    = 3'b011,
        CMD_WAIT    = 3'b100,
        CMD_POPCC   = 3'b101,
        CMD_IRQ_RETURN_INSTR    = 3'b110,
        CMD_TRAP    = 3'b111
    } eisvm_cmd_t;

endpackage : eisvm_pkg

// ===== include/eisvm_line_if.sv
// Control and request signals between the block and one external line
interface eisvm_line_if;
    logic [1:0] sense_code;
    logic       invert;
    logic       clear_pend;
    logic       ack;
    logic       req;
    logic       pend;

    modport ctrl (output sense_code, output invert, output clear_pend, output ack, input req, input pend);
    modport line (input sense_code, input invert, input clear_pend, input ack, output req, output pend);
endinterface : eisvm_line_if

// ===== hdl/eisvm_line.sv
// One external interrupt line: pin synchroniser, OR of pins, sense and pending latch
module eisvm_line
    import eisvm_pkg::*;
#(
    parameter int N = 4
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] pin_raw,
    input  wire logic [N-1:0] pin_sel,
    eisvm_line_if.line        bus
);

    logic [N-1:0] sync1_reg;
    logic [N-1:0] sync2_reg;
    logic [N-1:0] prev_reg;
    logic         pend_reg;
    logic         pend_next;

    // Each selected pin raises its own request; the line ORs them
    wire [N-1:0] rise_pin = sync2_reg & ~prev_reg & pin_sel;
    wire [N-1:0] fall_pin = ~sync2_reg & prev_reg & pin_sel;
    wire         level_hi = |(sync2_reg & pin_sel);
    wire         level_lo = |(~sync2_reg & pin_sel);
    wire         rise_evt = |rise_pin;
    wire         fall_evt = |fall_pin;
    wire         inv      = bus.invert;

    // Pins idle high, so the samples start high to avoid a false edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            prev_reg  <= '1;
            pend_reg  <= 1'b0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            pend_reg  <= pend_next;
        end
    end

    logic edge_evt;
    logic level_act;

    always_comb begin
        edge_evt  = 1'b0;
        level_act = 1'b0;
        case (bus.sense_code)
            SENSE_FALL_LOW: begin
                edge_evt  = inv ? rise_evt : fall_evt;
                level_act = inv ? level_hi : level_lo;
            end
            SENSE_RISE: edge_evt = inv ? fall_evt : rise_evt;
            SENSE_FALL: edge_evt = inv ? rise_evt : fall_evt;
            default:    edge_evt = rise_evt | fall_evt;
        endcase
    end

    // A new edge wins over a service entry or a sensitivity rewrite
    always_comb begin
        pend_next = pend_reg;
        if (bus.ack || bus.clear_pend) begin
            pend_next = 1'b0;
        end
        if (edge_evt) begin
            pend_next = 1'b1;
        end
    end

    assign bus.pend = pend_reg;
    assign bus.req  = pend_reg | level_act;

    property p_edge_latch;
        @(posedge clock) disable iff (!rst_n)
        edge_evt |=> pend_reg;
    endproperty
    a_edge_latch: assert property (p_edge_latch) else $error("edge event not latched");

    property p_ack_clear;
        @(posedge clock) disable iff (!rst_n)
        (bus.ack || bus.clear_pend) && !edge_evt |=> !pend_reg;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("pending not cleared");

    property p_level_req;
        @(posedge clock) disable iff (!rst_n)
        bus.sense_code == SENSE_FALL_LOW && (inv ? level_hi : level_lo) |-> bus.req;
    endproperty
    a_level_req: assert property (p_level_req) else $error("level request missing");

endmodule : eisvm_line

// ===== hdl/eisvm_top.sv
// External interrupt sense, CPU priority bits and vector map with APB registers
module eisvm_top
    import eisvm_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                instr_valid,
    input  wire eisvm_cmd_t          instr_cmd,
    input  wire logic [7:0]          pop_data,
    input  wire logic                irq_enter,
    input  wire logic [1:0]          enter_level,
    output logic [7:0]               cond_code,
    output logic [1:0]               prio_level,
    output logic                     jump_if_masked,
    output logic                     jump_if_unmasked,
    input  wire logic                top_level_irq,
    input  wire logic [PINS_A-1:0]   port_a_pins,
    input  wire logic [PINS_A-1:0]   port_a_sel,
    input  wire logic [PINS_F-1:0]   port_f_pins,
    input  wire logic [PINS_F-1:0]   port_f_sel,
    input  wire logic [PINS_B-1:0]   port_b_pins,
    input  wire logic [PINS_B-1:0]   port_b_sel,
    input  wire logic                timebase_req,
    input  wire logic                spi_req,
    input  wire logic                timer_a_req,
    input  wire logic                timer_b_req,
    input  wire logic                serial_req,
    input  wire logic                volt_det_req,
    input  wire logic                i2c_req,
    input  wire logic                art_req,
    input  wire logic                spi_slave_mode,
    input  wire logic                art_ext_clock,
    input  wire logic                irq_ack,
    input  wire logic [3:0]          ack_src,
    output logic                     irq_pending,
    output logic [3:0]               irq_src,
    output logic [15:0]              irq_vector,
    output logic                     halt_wake
);

    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [7:0]  cc_reg;
    logic [7:0]  cc_next;
    logic [31:0] rdata_reg;
    logic [3:0]  src_reg;
    logic [15:0] vec_reg;
    logic        pend_out_reg;
    logic        wake_reg;
    logic        top_sync1_reg;
    logic        top_sync2_reg;
    logic        top_prev_reg;
    logic        top_pend_reg;
    logic        top_pend_next;
    logic [13:0] req_vec;
    logic [3:0]  win_src;
    logic        win_any;

    eisvm_line_if line_if [NUM_LINES] ();

    // APB decode
    wire setup_phase = psel & ~penable;
    wire access      = psel & penable;
    wire hit_ctrl    = paddr == ADDR_CTRL;
    wire hit_status  = paddr == ADDR_STATUS;
    wire hit_cc      = paddr == ADDR_CC;
    wire addr_ok     = hit_ctrl | hit_status | hit_cc;
    wire ctrl_wr     = access & pwrite & hit_ctrl;

    assign pready  = 1'b1;
    assign pslverr = access & ~addr_ok;
    assign prdata  = rdata_reg;

    // Sensitivity fields can change at any time; a change clears every line's pending latch
    wire sense_change = ctrl_wr & (pwdata[7:CTRL_SENSE_LSB] != ctrl_reg[7:CTRL_SENSE_LSB]);
    wire top_edge_new = ctrl_reg[CTRL_TOP_EN] ? ctrl_reg[CTRL_TOP_EDGE] : pwdata[CTRL_TOP_EDGE];

    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr) begin
            ctrl_next                = pwdata[7:0];
            ctrl_next[CTRL_TOP_EDGE] = top_edge_new;
        end
    end

    logic [31:0] status_word;
    logic [31:0] rd_mux;

    always_comb begin
        status_word                               = '0;
        status_word[STAT_REQ_LSB +: NUM_SRC]      = req_vec;
        status_word[STAT_SRC_LSB +: 4]            = src_reg;
        status_word[STAT_PENDING]                 = pend_out_reg;
        status_word[STAT_WAKE]                    = wake_reg;
    end

    always_comb begin
        rd_mux = '0;
        if (hit_ctrl) begin
            rd_mux = {24'h000000, ctrl_reg};
        end else if (hit_status) begin
            rd_mux = status_word;
        end else if (hit_cc) begin
            rd_mux = {24'h000000, cc_reg};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg  <= CTRL_RESET;
            rdata_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            if (setup_phase && !pwrite) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // CPU priority bits; service entry takes precedence over an instruction
    always_comb begin
        cc_next = cc_reg;
        if (irq_enter) begin
            cc_next[CC_I1] = enter_level[1];
            cc_next[CC_I0] = enter_level[0];
        end else if (instr_valid) begin
            case (instr_cmd)
                CMD_ENABLE, CMD_HALT, CMD_WAIT: begin
                    cc_next[CC_I1] = PRIO_LEVEL0[1];
                    cc_next[CC_I0] = PRIO_LEVEL0[0];
                end
                CMD_DISABLE, CMD_TRAP: begin
                    cc_next[CC_I1] = PRIO_LEVEL3[1];
                    cc_next[CC_I0] = PRIO_LEVEL3[0];
                end
                CMD_POPCC, CMD_IRQ_RETURN_INSTR: begin
                    cc_next = pop_data | CC_FIXED_ONES;
                end
                default: begin
                    cc_next = cc_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cc_reg <= CC_RESET;
        end else begin
            cc_reg <= cc_next;
        end
    end

    assign cond_code        = cc_reg;
    assign prio_level       = {cc_reg[CC_I1], cc_reg[CC_I0]};
    assign jump_if_masked   = prio_level == PRIO_LEVEL3;
    assign jump_if_unmasked = prio_level != PRIO_LEVEL3;

    // Top-level interrupt pin
    wire top_rise = top_sync2_reg & ~top_prev_reg;
    wire top_fall = ~top_sync2_reg & top_prev_reg;
    wire top_evt  = ctrl_reg[CTRL_TOP_EN] & (ctrl_reg[CTRL_TOP_EDGE] ? top_rise : top_fall);
    wire top_ack  = irq_ack & (ack_src == SRC_TOP);

    always_comb begin
        top_pend_next = top_pend_reg;
        if (top_ack) begin
            top_pend_next = 1'b0;
        end
        if (top_evt) begin
            top_pend_next = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            top_sync1_reg <= 1'b1;
            top_sync2_reg <= 1'b1;
            top_prev_reg  <= 1'b1;
            top_pend_reg  <= 1'b0;
        end else begin
            top_sync1_reg <= top_level_irq;
            top_sync2_reg <= top_sync1_reg;
            top_prev_reg  <= top_sync2_reg;
            top_pend_reg  <= top_pend_next;
        end
    end

    // External lines: 0 port A, 1 port F, 2 port B low, 3 port B high
    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++) begin : g_cfg
            localparam bit HI = g >= 2;
            assign line_if[g].sense_code = HI ? ctrl_reg[CTRL_SENSE_HI_LSB +: 2]
                                              : ctrl_reg[CTRL_SENSE_LO_LSB +: 2];
            // Only lines 0 and 2 have an invert bit
            assign line_if[g].invert     = (g == 0) ? ctrl_reg[CTRL_POL_A] :
                                           (g == 2) ? ctrl_reg[CTRL_POL_B] : 1'b0;
            assign line_if[g].clear_pend = sense_change;
            assign line_if[g].ack        = irq_ack & (ack_src == SRC_LINE0 + 4'(g));
            assign req_vec[g + 2]        = line_if[g].req;
        end
    endgenerate

    eisvm_line #(.N(PINS_A)) u_line0 (
        .clock   (clock),
        .rst_n   (rst_n),
        .pin_raw (port_a_pins),
        .pin_sel (port_a_sel),
        .bus     (line_if[0])
    );

    eisvm_line #(.N(PINS_F)) u_line1 (
        .clock   (clock),
        .rst_n   (rst_n),
        .pin_raw (port_f_pins),
        .pin_sel (port_f_sel),
        .bus     (line_if[1])
    );

    eisvm_line #(.N(PINS_B / 2)) u_line2 (
        .clock   (clock),
        .rst_n   (rst_n),
        .pin_raw (port_b_pins[PINS_B/2-1:0]),
        .pin_sel (port_b_sel[PINS_B/2-1:0]),
        .bus     (line_if[2])
    );

    eisvm_line #(.N(PINS_B / 2)) u_line3 (
        .clock   (clock),
        .rst_n   (rst_n),
        .pin_raw (port_b_pins[PINS_B-1:PINS_B/2]),
        .pin_sel (port_b_sel[PINS_B-1:PINS_B/2]),
        .bus     (line_if[3])
    );

    // Request vector in hardware priority order; slot 6 stays empty
    assign req_vec[0]  = top_pend_reg;
    assign req_vec[1]  = timebase_req;
    assign req_vec[6]  = 1'b0;
    assign req_vec[7]  = spi_req;
    assign req_vec[8]  = timer_a_req;
    assign req_vec[9]  = timer_b_req;
    assign req_vec[10] = serial_req;
    assign req_vec[11] = volt_det_req;
    assign req_vec[12] = i2c_req;
    assign req_vec[13] = art_req;

    // Lowest number wins
    always_comb begin
        win_src = '0;
        win_any = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req_vec[i]) begin
                win_src = 4'(i);
                win_any = 1'b1;
            end
        end
    end

    wire [13:0] cond_ok   = {art_ext_clock, 5'b00000, spi_slave_mode, 7'b0000000};
    wire [13:0] wake_mask = HALT_CAP_MASK & (~HALT_COND_MASK | cond_ok);
    wire        wake_any  = |(req_vec & wake_mask);
    wire [15:0] win_vec   = VEC_SRC0 - {11'h000, win_src, 1'b0};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            src_reg      <= '0;
            vec_reg      <= VEC_RESET;
            pend_out_reg <= 1'b0;
            wake_reg     <= 1'b0;
        end else begin
            src_reg      <= win_src;
            vec_reg      <= win_any ? win_vec : VEC_RESET;
            pend_out_reg <= win_any;
            wake_reg     <= wake_any;
        end
    end

    assign irq_pending = pend_out_reg;
    assign irq_src     = src_reg;
    assign irq_vector  = vec_reg;
    assign halt_wake   = wake_reg;

    property p_enable;
        @(posedge clock) disable iff (!rst_n)
        instr_valid && instr_cmd == CMD_ENABLE && !irq_enter |=> prio_level == 2'b10 && !jump_if_masked;
    endproperty
    a_enable: assert property (p_enable) else $error("enable did not set level 0");

    property p_disable;
        @(posedge clock) disable iff (!rst_n)
        instr_valid && instr_cmd == CMD_DISABLE && !irq_enter |=> prio_level == 2'b11 && jump_if_masked;
    endproperty
    a_disable: assert property (p_disable) else $error("disable did not set level 3");

    property p_jump;
        @(posedge clock) disable iff (!rst_n)
        jump_if_masked == (cond_code[5] & cond_code[3]) && jump_if_unmasked == !jump_if_masked;
    endproperty
    a_jump: assert property (p_jump) else $error("jump condition wrong");

    property p_pop;
        @(posedge clock) disable iff (!rst_n)
        instr_valid && instr_cmd == CMD_POPCC && !irq_enter |=> cond_code[5:0] == $past(pop_data[5:0]);
    endproperty
    a_pop: assert property (p_pop) else $error("pop did not restore flags");

    property p_halt_wait;
        @(posedge clock) disable iff (!rst_n)
        instr_valid && (instr_cmd == CMD_HALT || instr_cmd == CMD_WAIT) && !irq_enter
            ##1 !instr_valid && !irq_enter |=> prio_level == 2'b10;
    endproperty
    a_halt_wait: assert property (p_halt_wait) else $error("priority not held after halt");

    property p_vector;
        @(posedge clock) disable iff (!rst_n)
        irq_pending |-> irq_vector == 16'hFFFA - {11'h000, irq_src, 1'b0} && irq_src != 4'h6;
    endproperty
    a_vector: assert property (p_vector) else $error("vector does not match source");

    property p_priority;
        @(posedge clock) disable iff (!rst_n)
        req_vec[0] |=> irq_pending && irq_src == 4'h0;
    endproperty
    a_priority: assert property (p_priority) else $error("top source not chosen first");

    property p_spi_wake;
        @(posedge clock) disable iff (!rst_n)
        req_vec == 14'h0080 && !spi_slave_mode |=> !halt_wake;
    endproperty
    a_spi_wake: assert property (p_spi_wake) else $error("serial peripheral woke in master mode");

    property p_art_wake;
        @(posedge clock) disable iff (!rst_n)
        req_vec == 14'h2000 |=> halt_wake == $past(art_ext_clock);
    endproperty
    a_art_wake: assert property (p_art_wake) else $error("timer wake gating wrong");

    property p_top_edge_hold;
        @(posedge clock) disable iff (!rst_n)
        ctrl_wr && ctrl_reg[0] |=> ctrl_reg[1] == $past(ctrl_reg[1]);
    endproperty
    a_top_edge_hold: assert property (p_top_edge_hold) else $error("edge select changed while enabled");

    property p_rewrite_clear;
        @(posedge clock) disable iff (!rst_n)
        sense_change && !u_line3.edge_evt |=> !line_if[3].pend;
    endproperty
    a_rewrite_clear: assert property (p_rewrite_clear) else $error("rewrite kept pending");

endmodule : eisvm_top

// ===== sim/eisvm_far_model.sv
// Far-side model: external port pins and peripheral request lines
module eisvm_far_model
    import eisvm_pkg::*;
(
    output logic              top_level_irq,
    output logic [PINS_A-1:0] port_a_pins,
    output logic [PINS_F-1:0] port_f_pins,
    output logic [PINS_B-1:0] port_b_pins,
    output logic [7:0]        periph_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins idle high, requests idle low
    initial begin
        top_level_irq = 1'b1;
        port_a_pins = 4'hF;
        port_f_pins = 3'h7;
        port_b_pins = 8'hFF;
        periph_req = 8'h00;
    end
    // Called just after a rising edge
    task automatic drive_lines(input logic t, input logic [3:0] a, input logic [7:0] b, input logic [7:0] r);
        top_level_irq <= t;
        port_a_pins <= a;
        port_b_pins <= b;
        periph_req <= r;
    endtask : drive_lines
endmodule : eisvm_far_model

// ===== sim/tb_eisvm_top.sv
// Self-checking bench for the external interrupt sense block
module tb_eisvm_top
    import eisvm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, instr_valid = 1'b0;
    logic        irq_enter = 1'b0, spi_slave_mode = 1'b0, art_ext_clock = 1'b0, irq_ack = 1'b0, err;
    logic        pready, pslverr, jump_if_masked, jump_if_unmasked, top_level_irq, irq_pending, halt_wake;
    logic [7:0]  paddr = 8'h00, pop_data = 8'h00, port_b_sel = 8'hF0, cond_code, port_b_pins, periph_req;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0]  enter_level = 2'b00, prio_level;
    logic [3:0]  port_a_sel = 4'hF, ack_src = 4'h0, port_a_pins, irq_src;
    logic [2:0]  port_f_sel = 3'h7, port_f_pins;
    logic [15:0] irq_vector;
    eisvm_cmd_t  instr_cmd = CMD_NONE;
    int          bad_count = 0, num_checks = 0;

    eisvm_top dut_u (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .instr_valid, .instr_cmd, .pop_data, .irq_enter, .enter_level, .cond_code, .prio_level, .jump_if_masked,
        .jump_if_unmasked, .top_level_irq, .port_a_pins, .port_a_sel, .port_f_pins, .port_f_sel, .port_b_pins,
        .port_b_sel, .timebase_req(periph_req[0]), .spi_req(periph_req[1]), .timer_a_req(periph_req[2]),
        .timer_b_req(periph_req[3]), .serial_req(periph_req[4]), .volt_det_req(periph_req[5]),
        .i2c_req(periph_req[6]), .art_req(periph_req[7]), .spi_slave_mode, .art_ext_clock, .irq_ack,
        .ack_src, .irq_pending, .irq_src, .irq_vector, .halt_wake);
    eisvm_far_model far_u (.top_level_irq, .port_a_pins, .port_f_pins, .port_b_pins, .periph_req);

    initial forever #5 clock = ~clock;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Setup cycle, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clock);
        end
        check("pready", pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    task automatic cpu(input eisvm_cmd_t c, input logic [7:0] d);
        instr_valid <= 1'b1;
        instr_cmd <= c;
        pop_data <= d;
        @(posedge clock);
        instr_valid <= 1'b0;
        @(posedge clock);
    endtask : cpu

    task automatic ack(input logic [3:0] s);
        irq_ack <= 1'b1;
        ack_src <= s;
        @(posedge clock);
        irq_ack <= 1'b0;
        @(posedge clock);
    endtask : ack

    task automatic expect_irq(input logic p, input logic [3:0] s);
        repeat (6) @(posedge clock);
        check("irq_pending", irq_pending, p);
        if (p) begin
            check("irq_src", irq_src, s);
            check("irq_vector", irq_vector, VEC_SRC0 - 16'(2 * s));
        end
    endtask : expect_irq

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl", rd, 32'h0);
        check("prio", prio_level, 2'b11);
        cpu(CMD_ENABLE, 8'h00);
        check("prio", prio_level, 2'b10);
        check("jump_unmasked", jump_if_unmasked, 1'b1);
        cpu(CMD_DISABLE, 8'h00);
        check("prio", prio_level, 2'b11);
        check("jump_masked", jump_if_masked, 1'b1);
        cpu(CMD_POPCC, 8'h17);
        check("cond_code", cond_code, 8'hD7);
        cpu(CMD_WAIT, 8'h00);
        check("prio", prio_level, 2'b10);
        irq_enter <= 1'b1;
        enter_level <= 2'b01;
        cpu(CMD_ENABLE, 8'h00);
        irq_enter <= 1'b0;
        check("prio", prio_level, 2'b01);
        cpu(CMD_TRAP, 8'h00);
        check("prio", prio_level, 2'b11);
        cpu(CMD_HALT, 8'h00);
        check("prio", prio_level, 2'b10);
        cpu(CMD_IRQ_RETURN_INSTR, 8'h28);
        check("cond_code", cond_code, 8'hE8);
        cpu(CMD_DISABLE, 8'h00);
        far_u.drive_lines(1'b1, 4'hD, 8'hFF, 8'h00);
        expect_irq(1'b1, SRC_LINE0);
        ack(4'h2);
        expect_irq(1'b1, 4'h2);
        far_u.drive_lines(1'b1, 4'hF, 8'hFF, 8'h00);
        repeat (6) @(posedge clock);
        ack(4'h2);
        expect_irq(1'b0, 4'h0);
        apb(1'b1, ADDR_CTRL, 32'h04);
        expect_irq(1'b1, 4'h2);
        apb(1'b1, ADDR_CTRL, 32'h10);
        expect_irq(1'b0, 4'h0);
        far_u.drive_lines(1'b1, 4'hE, 8'hFF, 8'h00);
        expect_irq(1'b1, 4'h2);
        far_u.drive_lines(1'b1, 4'hF, 8'hFF, 8'h00);
        expect_irq(1'b1, 4'h2);
        apb(1'b1, ADDR_CTRL, 32'h18);
        expect_irq(1'b0, 4'h0);
        apb(1'b1, ADDR_CTRL, 32'h60);
        far_u.drive_lines(1'b1, 4'hF, 8'hEF, 8'h00);
        expect_irq(1'b0, 4'h0);
        far_u.drive_lines(1'b1, 4'hF, 8'hFF, 8'h00);
        expect_irq(1'b1, 4'h5);
        ack(4'h5);
        apb(1'b1, ADDR_CTRL, 32'h01);
        far_u.drive_lines(1'b0, 4'hF, 8'hFF, 8'h02);
        expect_irq(1'b1, SRC_TOP);
        apb(1'b1, ADDR_CTRL, 32'h03);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl", rd, 32'h01);
        ack(SRC_TOP);
        far_u.drive_lines(1'b1, 4'hF, 8'hFF, 8'h02);
        expect_irq(1'b1, 4'h7);
        check("halt_wake", halt_wake, 1'b0);
        spi_slave_mode <= 1'b1;
        repeat (3) @(posedge clock);
        check("halt_wake", halt_wake, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("status", rd[21:16], 6'h37);
        apb(1'b0, 8'h0C, 32'h0);
        check("pslverr", err, 1'b1);
        far_u.drive_lines(1'b1, 4'hF, 8'hFF, 8'h80);
        expect_irq(1'b1, 4'hD);
        check("halt_wake", halt_wake, 1'b0);
        art_ext_clock <= 1'b1;
        repeat (3) @(posedge clock);
        check("halt_wake", halt_wake, 1'b1);
        wrap_up();
    end

    initial begin
        #20000;
        bad_count++;
        wrap_up();
    end
endmodule : tb_eisvm_top
